// ---- verilog/pwm_sec_pkg.sv ----
package pwm_sec_pkg;
  localparam logic [3:0]  ADDR_SEC_PRESCALE  = 4'h0;
  localparam logic [3:0]  ADDR_SEC_PERIOD    = 4'h1;
  localparam logic [3:0]  ADDR_SEC_COMPARE   = 4'h2;
  localparam logic [3:0]  ADDR_CHOP          = 4'h3;
  localparam logic [3:0]  ADDR_MASTER_DUTY   = 4'h4;
  localparam logic [3:0]  ADDR_GEN_CONTROL   = 4'h5;
  localparam logic [3:0]  ADDR_SEC_COUNTER   = 4'h6;
  localparam logic [3:0]  ADDR_GEN_STATUS    = 4'h7;
  localparam logic [15:0] SEC_PERIOD_RESET   = 16'hfff8;
  localparam logic [2:0]  PRESCALE_RESERVED  = 3'h7;
  localparam logic [15:0] LOW3_MASK          = 16'hfff8;
  localparam logic [15:0] CHOP_MASK          = 16'h83f8;
  localparam int          CHOP_EN_BIT        = 15;
  localparam int          FLT_PEND_BIT       = 15;
  localparam int          CL_PEND_BIT        = 14;
  localparam int          TRG_PEND_BIT       = 13;
  localparam int          FLT_IEN_BIT        = 12;
  localparam int          CL_IEN_BIT         = 11;
  localparam int          TRG_IEN_BIT        = 10;
  localparam int          ITB_BIT            = 9;
  localparam int          DUTY_SOURCE_SEL_BIT           = 8;
  localparam int          DEAD_TIME_COMP_POLARITY_BIT           = 5;
  localparam int          MASTER_TIMEBASE_SEL_BIT           = 3;
  localparam int          CAM_BIT            = 2;
  localparam int          EXTERNAL_PERIOD_RESET_CTL_BIT          = 1;
  localparam int          IUE_BIT            = 0;
  localparam logic [15:0] GEN_CTL_WMASK      = 16'h1fef;
  localparam logic [15:0] MIN_DUTY           = 16'h0008;
  localparam logic [1:0]  DTC_COMP           = 2'h3;
  localparam int          EDGE_NS            = 40;
  localparam int          CLK_MHZ            = 200;
  localparam int          EDGE_CYC           = (EDGE_NS * CLK_MHZ) / 1000;
  typedef enum logic [1:0] {
    DT_POSITIVE = 2'b00,
    DT_NEGATIVE = 2'b01,
    DT_DISABLED = 2'b10,
    DT_COMPENS  = 2'b11
  } dead_time_t;
endpackage

// ---- verilog/pwm_prescale_if.sv ----
`timescale 1ns/100ps
interface pwm_prescale_if;
  logic [2:0] sel;
  logic       run;
  logic       tick;
  modport ctrl (output sel, output run, input tick);
  modport div  (input sel, input run, output tick);
endinterface // pwm_prescale_if

// ---- verilog/pwm_prescaler.sv ----
`timescale 1ns/100ps
module pwm_prescaler (
  input  wire logic mclk,
  input  wire logic rst_n,
  pwm_prescale_if.div pif
);
  import pwm_sec_pkg::*;
  logic [5:0] count;
  logic [5:0] limit;
  // Code n divides by 2**n; reserved code stalls the ticks
  assign limit = (6'h01 << pif.sel) - 6'h01;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= 6'h00;
      pif.tick <= 1'b0;
    end else if (!pif.run || pif.sel == PRESCALE_RESERVED) begin
      count    <= 6'h00;
      pif.tick <= 1'b0;
    end else begin
      count    <= (count >= limit) ? 6'h00 : count + 6'h01;
      pif.tick <= (count >= limit);
    end
  end
endmodule // pwm_prescaler

// ---- verilog/pwm_secondary_timebase.sv ----
// Function
// - three-bit secondary prescaler, codes divide by 1..64, 111 reserved, reset 0 (divide by 1)
// - sixteen-bit secondary period, resets to 0xfff8
// - secondary compare keeps bits 15:3, low three read zero
// - chop register top bit enables the chop generator, reset zero
// - chop divider in bits 9:3, other bits read zero
// - chop frequency is 1/(16.64*(divider+1)*input clock period)
// - chop generator clocked from primary prescaler, not secondary
// - sixteen-bit shared master duty register, fully writable, reset zero
// - pulse width clamped between 0x0008 and period minus 0x0008
// - resolution coarsens to three LSBs within 40 ns of edges
// - fault pending set by hardware, cleared by clearing its enable
// - current-limit pending set by hardware, cleared with its enable
// - trigger pending set by hardware, enable gates the request
// - independent bit selects own phase as period, else primary period
// - centre-aligned works only with the independent time base
// - compensation polarity only effective when dead time control is 11
// - centre-aligned mode drops low three bits of duty, phase, dead time; the code drops them from duty and counter only
// - duty source bit picks shared master duty or own duty registers
// - time base select bit picks secondary or primary master base
// - immediate update applies duty at once, else at period boundary
// - dead time field: positive, negative, disabled, compensation
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module pwm_secondary_timebase (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        module_enable,
  input  wire logic [2:0]  input_clock_prescale_sel,
  input  wire logic        primary_tick,
  input  wire logic [15:0] primary_period_value,
  input  wire logic [15:0] primary_master_counter,
  input  wire logic [15:0] primary_phase_value,
  input  wire logic [15:0] primary_duty_value,
  input  wire logic [15:0] secondary_duty_value,
  input  wire logic        current_limit_mode,
  input  wire logic        fault_event,
  input  wire logic        current_limit_event,
  input  wire logic        trigger_event,
  output logic             pwm_out,
  output logic             chop_clock,
  output logic             secondary_event,
  output logic             generator_irq,
  output logic [1:0]       dead_time_mode,
  output logic             dead_time_comp_polarity,
  output logic             center_aligned,
  output logic             external_period_reset_ctl
);
  import pwm_sec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs pass two flip-flops
  logic [2:0] ev_meta;
  logic [2:0] ev_sync;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ev_meta <= 3'h0;
      ev_sync <= 3'h0;
    end else begin
      ev_meta <= {fault_event, current_limit_event, trigger_event};
      ev_sync <= ev_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [2:0]  secondary_prescale_reg;
  logic [15:0] secondary_period_value;
  logic [15:0] secondary_event_compare_value;
  logic [15:0] chop_reg;
  logic [15:0] shared_master_duty;
  logic [15:0] generator_control_reg;
  logic [15:0] secondary_master_counter;
  logic        fault_irq_pending;
  logic        current_limit_irq_pending;
  logic        trigger_irq_pending;

  wire wr_pre  = wr && addr == ADDR_SEC_PRESCALE;
  wire wr_per  = wr && addr == ADDR_SEC_PERIOD;
  wire wr_cmp  = wr && addr == ADDR_SEC_COMPARE;
  wire wr_chop = wr && addr == ADDR_CHOP;
  wire wr_mdc  = wr && addr == ADDR_MASTER_DUTY;
  wire wr_ctl  = wr && addr == ADDR_GEN_CONTROL;

  wire fault_irq_enable         = generator_control_reg[FLT_IEN_BIT];
  wire current_limit_irq_enable = generator_control_reg[CL_IEN_BIT];
  wire trigger_irq_enable       = generator_control_reg[TRG_IEN_BIT];
  wire independent_period_sel   = generator_control_reg[ITB_BIT];
  wire duty_source_sel          = generator_control_reg[DUTY_SOURCE_SEL_BIT];
  wire master_timebase_sel      = generator_control_reg[MASTER_TIMEBASE_SEL_BIT];
  wire immediate_update_enable  = generator_control_reg[IUE_BIT];
  wire chop_generator_enable    = chop_reg[CHOP_EN_BIT];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_prescale_reg        <= 3'h0;
      secondary_period_value        <= SEC_PERIOD_RESET;
      secondary_event_compare_value <= 16'h0000;
      chop_reg                      <= 16'h0000;
      shared_master_duty            <= 16'h0000;
      generator_control_reg         <= 16'h0000;
    end else begin
      if (wr_pre) secondary_prescale_reg <= wdata[2:0];
      if (wr_per) secondary_period_value <= wdata;
      if (wr_cmp) secondary_event_compare_value <= wdata & LOW3_MASK;
      if (wr_chop) chop_reg <= wdata & CHOP_MASK;
      if (wr_mdc) shared_master_duty <= wdata;
      if (wr_ctl) generator_control_reg <= wdata & GEN_CTL_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags: a hardware set wins over nothing, an enable of zero clears
  wire next_fault = fault_irq_enable
                    && (ev_sync[2] || fault_irq_pending);
  wire next_cl    = current_limit_irq_enable
                    && (ev_sync[1] || current_limit_irq_pending);
  wire next_trg   = trigger_irq_enable
                    && (ev_sync[0] || trigger_irq_pending);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_irq_pending         <= 1'b0;
      current_limit_irq_pending <= 1'b0;
      trigger_irq_pending       <= 1'b0;
      generator_irq             <= 1'b0;
    end else begin
      fault_irq_pending         <= next_fault;
      current_limit_irq_pending <= next_cl;
      trigger_irq_pending       <= next_trg;
      generator_irq             <= next_fault || next_cl || next_trg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Secondary prescaler and counter
  pwm_prescale_if sec_pif ();
  assign sec_pif.sel = secondary_prescale_reg;
  assign sec_pif.run = module_enable;
  pwm_prescaler u_sec_prescaler (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pif   (sec_pif.div)
  );
  wire sec_wrap = secondary_master_counter >= secondary_period_value;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_master_counter <= 16'h0000;
      secondary_event          <= 1'b0;
    end else if (!module_enable) begin
      secondary_master_counter <= 16'h0000;
      secondary_event          <= 1'b0;
    end else if (sec_pif.tick) begin
      secondary_master_counter <= sec_wrap ? 16'h0000
                                  : secondary_master_counter + 16'h0001;
      secondary_event <= secondary_master_counter
                         == secondary_event_compare_value;
    end else begin
      secondary_event <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chop clock: primary ticks; each 8.32 ns step is eight ticks,
  // one half-period is (divider+1) steps, so the period is 16.64*(d+1)
  wire [6:0]  chop_div   = chop_reg[9:3];
  wire [9:0]  chop_half  = {chop_div, 3'h7};
  logic [9:0] chop_count;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chop_count <= 10'h000;
      chop_clock <= 1'b0;
    end else if (!chop_generator_enable || !module_enable) begin
      chop_count <= 10'h000;
      chop_clock <= 1'b0;
    end else if (primary_tick) begin
      if (chop_count >= chop_half) begin
        chop_count <= 10'h000;
        chop_clock <= ~chop_clock;
      end else begin
        chop_count <= chop_count + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator: period, duty, time base and alignment selection
  wire        cam_active = center_aligned;
  wire [15:0] gen_period = independent_period_sel ? primary_phase_value
                           : primary_period_value;
  wire [15:0] duty_src   = duty_source_sel ? shared_master_duty
                           : primary_duty_value;
  wire [15:0] gen_count  = master_timebase_sel ? secondary_master_counter
                           : primary_master_counter;
  wire [15:0] per_eff    = master_timebase_sel ? secondary_period_value
                           : gen_period;
  logic [15:0] active_duty;
  // Near either edge the hardware cannot place fine edges: drop low bits
  wire near_edge = (duty_src < 16'(EDGE_CYC + 8))
                   || (duty_src + 16'(EDGE_CYC + 8) > per_eff);
  wire [15:0] duty_res = (cam_active || near_edge) ? (duty_src & LOW3_MASK)
                         : duty_src;
  wire [15:0] duty_max = per_eff - MIN_DUTY;
  wire [15:0] duty_clamped = (duty_res < MIN_DUTY) ? MIN_DUTY
                             : (duty_res > duty_max) ? duty_max
                             : duty_res;
  wire [15:0] cnt_eff = cam_active ? (gen_count & LOW3_MASK) : gen_count;
  wire        at_boundary = (gen_count == 16'h0000);
  logic       active_level;
  assign active_level = module_enable && (cnt_eff < active_duty);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_duty <= MIN_DUTY;
      pwm_out     <= 1'b0;
    end else begin
      if (immediate_update_enable || at_boundary)
        active_duty <= duty_clamped;
      pwm_out <= active_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs
  wire [1:0] dead_time_control = generator_control_reg[7:6];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dead_time_mode            <= DT_POSITIVE;
      dead_time_comp_polarity   <= 1'b0;
      center_aligned            <= 1'b0;
      external_period_reset_ctl <= 1'b0;
    end else begin
      dead_time_mode <= dead_time_control;
      dead_time_comp_polarity <= (dead_time_control == DTC_COMP)
                                 && generator_control_reg[DEAD_TIME_COMP_POLARITY_BIT];
      center_aligned <= independent_period_sel
                        && generator_control_reg[CAM_BIT];
      external_period_reset_ctl <= generator_control_reg[EXTERNAL_PERIOD_RESET_CTL_BIT]
                                   && independent_period_sel
                                   && !current_limit_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe, zero otherwise
  logic [15:0] rd_mux;
  always_comb begin
    case (addr)
      ADDR_SEC_PRESCALE: rd_mux = {13'h0000, secondary_prescale_reg};
      ADDR_SEC_PERIOD:   rd_mux = secondary_period_value;
      ADDR_SEC_COMPARE:  rd_mux = secondary_event_compare_value;
      ADDR_CHOP:         rd_mux = chop_reg;
      ADDR_MASTER_DUTY:  rd_mux = shared_master_duty;
      ADDR_GEN_CONTROL:  rd_mux = {fault_irq_pending, current_limit_irq_pending,
                                   trigger_irq_pending,
                                   generator_control_reg[12:0]};
      ADDR_SEC_COUNTER:  rd_mux = secondary_master_counter;
      ADDR_GEN_STATUS:   rd_mux = active_duty;
      default:           rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rdata <= 16'h0000;
    else rdata <= rd ? rd_mux : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_prescale_reset: assert property (@(posedge mclk)
    $rose(rst_n) |-> secondary_prescale_reg == 3'h0)
    else $error("prescale not reset to divide by one");
  a_period_reset: assert property (@(posedge mclk)
    $rose(rst_n) |-> secondary_period_value == 16'hfff8)
    else $error("period reset value wrong");
  a_compare_low_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    rd && addr == ADDR_SEC_COMPARE |=> rdata[2:0] == 3'h0)
    else $error("compare low bits not zero");
  a_chop_off_low: assert property (@(posedge mclk) disable iff (!rst_n)
    !chop_generator_enable |=> !chop_clock)
    else $error("chop clock runs while disabled");
  a_chop_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    (chop_reg & ~CHOP_MASK) == 16'h0000)
    else $error("chop reserved bits set");
  a_fault_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_ctl && !wdata[FLT_IEN_BIT] |=> ##1 !fault_irq_pending)
    else $error("fault pending not cleared");
  a_cl_set: assert property (@(posedge mclk) disable iff (!rst_n)
    current_limit_irq_enable && ev_sync[1] && !wr_ctl
    |=> current_limit_irq_pending)
    else $error("current-limit pending not set");
  a_trg_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    trigger_irq_pending |-> generator_irq)
    else $error("trigger pending without request");
  a_cam_needs_itb: assert property (@(posedge mclk) disable iff (!rst_n)
    center_aligned |-> $past(independent_period_sel))
    else $error("centre-aligned without independent base");
  a_dead_time_comp_polarity_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    dead_time_comp_polarity |-> dead_time_mode == DTC_COMP)
    else $error("polarity active outside compensation");
  a_counter_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    module_enable && sec_pif.tick && sec_wrap
    |=> secondary_master_counter == 16'h0000)
    else $error("secondary counter did not wrap");
  c_chop_toggle: cover property (@(posedge mclk) $rose(chop_clock));
  c_sec_event:   cover property (@(posedge mclk) secondary_event);
  c_fault_pend:  cover property (@(posedge mclk) fault_irq_pending);
  c_pwm_high:    cover property (@(posedge mclk) $rose(pwm_out));
endmodule // pwm_secondary_timebase

// ---- testbench/pwr_stage_model.sv ----
`timescale 1ns/100ps
module pwr_stage_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [2:0] trip_cmd,
  input  wire logic       slow,
  output logic            fault_event,
  output logic            current_limit_event,
  output logic            trigger_event
);
  logic [2:0] cnt [3];
  logic [2:0] pin;

  ////////////////////////////////////////////////////////////////////////////
  // A slow stage reports its trip three cycles late; each pin then stays
  // high three cycles so the two-flop synchroniser cannot miss it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '{default: 3'h0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (trip_cmd[i]) begin
          cnt[i] <= slow ? 3'h6 : 3'h3;
        end else if (cnt[i] != 3'h0) begin
          cnt[i] <= cnt[i] - 3'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = (cnt[i] != 3'h0) && (cnt[i] <= 3'h3);
    end
  end

  assign fault_event         = pin[0];
  assign current_limit_event = pin[1];
  assign trigger_event       = pin[2];
endmodule // pwr_stage_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import pwm_sec_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        module_enable = 1'b0;
  logic        primary_tick = 1'b0;
  logic [15:0] pcount = 16'h0000;
  logic [15:0] pduty = 16'h0080;
  logic        cl_mode = 1'b0;
  logic [2:0]  trip_cmd = 3'h0;
  logic        slow = 1'b0;
  logic [15:0] rdata;
  logic        pwm_out, chop_clock, secondary_event, generator_irq;
  logic [1:0]  dead_time_mode;
  logic        dt_pol, center_aligned, ext_reset;
  logic        fault_ev, cl_ev, trg_ev;
  logic [31:0] seed = 32'd83158;
  logic [15:0] exp_q [$];
  logic [15:0] e_r, v;
  logic [15:0] rst_vals [6] = '{16'h0000, 16'hfff8, 16'h0000, 16'h0000,
                                16'h0000, 16'h0000};
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;

  pwm_secondary_timebase pwm_secondary_timebase_i (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .module_enable(module_enable),
    .input_clock_prescale_sel(3'h0), .primary_tick(primary_tick),
    .primary_period_value(16'h0100), .primary_master_counter(pcount),
    .primary_phase_value(16'h00c0), .primary_duty_value(pduty),
    .secondary_duty_value(16'h0000), .current_limit_mode(cl_mode),
    .fault_event(fault_ev), .current_limit_event(cl_ev),
    .trigger_event(trg_ev), .pwm_out(pwm_out), .chop_clock(chop_clock),
    .secondary_event(secondary_event), .generator_irq(generator_irq),
    .dead_time_mode(dead_time_mode), .dead_time_comp_polarity(dt_pol),
    .center_aligned(center_aligned), .external_period_reset_ctl(ext_reset));

  pwr_stage_model pwr_stage_model_i (
    .mclk(mclk), .rst_n(rst_n), .trip_cmd(trip_cmd), .slow(slow),
    .fault_event(fault_ev), .current_limit_event(cl_ev),
    .trigger_event(trg_ev));

  ////////////////////////////////////////////////////////////////////////////
  always #2.5 mclk = ~mclk;

  // Primary prescaler ticks every other cycle, so chop timing differs
  // visibly from the secondary prescaler at any code other than 001
  always @(posedge mclk) begin
    primary_tick <= ~primary_tick;
    pcount <= (pcount >= 16'h0100) ? 16'h0000 : pcount + 16'h0001;
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end

  always @(posedge mclk) begin
    rd_q <= rd;
    if (rd_q) begin
      e_r = exp_q.pop_front();
      `CHK(rdata, e_r)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  task rnd(output logic [15:0] r);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    r = seed[15:0];
  endtask

  task automatic pulse(input int k);
    @(posedge mclk);
    trip_cmd[k] <= 1'b1;
    @(posedge mclk);
    trip_cmd <= 3'h0;
    repeat (10) @(posedge mclk);
  endtask

  // Cycles between two rising edges; zero when fewer than two arrive in time
  task automatic period_of(input bit chop, output int p);
    logic prev, cur;
    int   k, g;
    prev = 1'b1;
    k = 0;
    p = 0;
    for (g = 0; g < 1500 && k < 2; g++) begin
      @(posedge mclk);
      cur = chop ? chop_clock : secondary_event;
      p++;
      if (cur === 1'b1 && prev !== 1'b1) begin
        k++;
        if (k == 1) p = 0;
      end
      prev = cur;
    end
    if (k < 2) p = 0;
  endtask

  task close_out;
    $display("Counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_chk(i[3:0], rst_vals[i]);
    end
    rd_chk(4'h8, 16'h0000);
    wr_reg(4'h9, 16'hffff);
    rd_chk(ADDR_SEC_PRESCALE, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      wr_reg(ADDR_MASTER_DUTY, v);
      rd_chk(ADDR_MASTER_DUTY, v);
      wr_reg(ADDR_SEC_COMPARE, v);
      rd_chk(ADDR_SEC_COMPARE, v & 16'hfff8);
      wr_reg(ADDR_CHOP, v & 16'h7fff);
      rd_chk(ADDR_CHOP, v & 16'h03f8);
      wr_reg(ADDR_SEC_PERIOD, v);
      rd_chk(ADDR_SEC_PERIOD, v);
      wr_reg(ADDR_SEC_PRESCALE, v);
      rd_chk(ADDR_SEC_PRESCALE, v & 16'h0007);
    end
    wr_reg(ADDR_GEN_CONTROL, 16'hffff);
    rd_chk(ADDR_GEN_CONTROL, 16'h1fef);
    // Each event source, first disabled, then enabled and cleared
    for (int i = 0; i < 3; i++) begin
      wr_reg(ADDR_GEN_CONTROL, 16'h0000);
      pulse(i);
      rd_chk(ADDR_GEN_CONTROL, 16'h0000);
      wr_reg(ADDR_GEN_CONTROL, 16'h1000 >> i);
      slow <= i[0];
      pulse(i);
      `CHK(generator_irq, 1'b1)
      rd_chk(ADDR_GEN_CONTROL, (16'h8000 >> i) | (16'h1000 >> i));
      wr_reg(ADDR_GEN_CONTROL, 16'h0000);
      repeat (3) @(posedge mclk);
      `CHK(generator_irq, 1'b0)
      rd_chk(ADDR_GEN_CONTROL, 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_GEN_CONTROL, {8'h00, i[1:0], 6'h24});
      repeat (2) @(posedge mclk);
      `CHK(dead_time_mode, i[1:0])
      `CHK(dt_pol, (i == 3))
      `CHK(center_aligned, 1'b0)
    end
    // External reset control needs the independent base and CL mode zero
    wr_reg(ADDR_GEN_CONTROL, 16'h0202);
    repeat (2) @(posedge mclk);
    `CHK(ext_reset, 1'b1)
    cl_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(ext_reset, 1'b0)
    cl_mode <= 1'b0;
    // Mode bits change only while the module is stopped
    wr_reg(ADDR_GEN_CONTROL, 16'h0305);
    wr_reg(ADDR_MASTER_DUTY, 16'h0040);
    module_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(center_aligned, 1'b1)
    rd_chk(ADDR_GEN_STATUS, 16'h0040);
    // Own phase is the period here, so the widest pulse is phase minus 8
    wr_reg(ADDR_MASTER_DUTY, 16'h00f0);
    rd_chk(ADDR_GEN_STATUS, 16'h00b8);
    module_enable <= 1'b0;
    wr_reg(ADDR_GEN_CONTROL, 16'h0001);
    module_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk(ADDR_GEN_STATUS, 16'h0080);
    // Output high below the duty count, low above it; look at mid-cycle
    wait (pcount == 16'h0040);
    @(negedge mclk);
    `CHK(pwm_out, 1'b1)
    wait (pcount == 16'h00c0);
    @(negedge mclk);
    `CHK(pwm_out, 1'b0)
    @(posedge mclk);
    wr_reg(ADDR_SEC_PERIOD, 16'h0010);
    wr_reg(ADDR_SEC_COMPARE, 16'h0008);
    for (int i = 0; i < 4; i++) begin
      module_enable <= 1'b0;
      wr_reg(ADDR_SEC_PRESCALE, (i == 3) ? 16'h0007 : 16'(i));
      module_enable <= 1'b1;
      period_of(1'b0, n);
      `CHK(n, (i == 3) ? 0 : (17 << i))
    end
    // Secondary ticks are stopped now, so any chop edge is primary-driven
    for (int i = 1; i < 3; i++) begin
      wr_reg(ADDR_CHOP, 16'h0000);
      wr_reg(ADDR_CHOP, 16'(16'h8000 | (i << 3)));
      period_of(1'b1, n);
      `CHK(n, 32 * (i + 1))
    end
    wr_reg(ADDR_CHOP, 16'h0008);
    period_of(1'b1, n);
    `CHK(n, 0)
    close_out();
  end
endmodule // tb_top
